//--- rip_regs.vh
// ----------------------------------------------------------------------------
// constants of the rtc serial slave port
// ----------------------------------------------------------------------------
`ifndef RIP_REGS_VH
`define RIP_REGS_VH

// ----------------------------------------------------------------------------
// identifiers and pointer limits
// ----------------------------------------------------------------------------
`define RIP_ID_CSR    7'h6f       // 1101111, clock/control space
`define RIP_ID_MEM    7'h57       // 1010111, user memory
`define RIP_DIR_READ  1'b1        // direction bit value for a read
`define RIP_PTR_RST   8'h00       // pointer value after reset
`define RIP_CSR_LAST  8'h2f       // last clock/control location
`define RIP_MEM_LAST  8'h7f       // last user memory location
`define RIP_MEM_MASK  8'h7f       // memory word address bits
`define RIP_TGT_CSR   1'b0        // target code, clock/control
`define RIP_TGT_MEM   1'b1        // target code, user memory
`define RIP_BIT_LAST  3'h7        // index of the eighth bit

`endif

//--- rip_sync.v
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// two-stage synchroniser for asynchronous levels
// ----------------------------------------------------------------------------
module rip_sync #(
  parameter WIDTH = 4,                  // number of levels
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rstn,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;               // first stage, read only by second
  reg [WIDTH-1:0] sync_r;               // second stage

  // both stages reset to the idle levels
  always @(posedge clk_sys) begin
    if (!rstn) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule // rip_sync

//--- rip_fifo.v
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// small fifo with a registered output stage
// ----------------------------------------------------------------------------
module rip_fifo #(
  parameter WIDTH = 17,                 // word width
  parameter DEPTH = 8,                  // storage words
  parameter AW    = 3                   // index width, log2 of depth
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rstn,
  // filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];    // storage
  reg [AW-1:0]    wp_r;                 // write index
  reg [AW-1:0]    rp_r;                 // read index
  reg [AW:0]      cnt_r;                // words in storage
  reg             ov_r;                 // output stage holds a word
  reg [WIDTH-1:0] od_r;                 // output stage word

  wire do_push = in_valid && in_ready;
  // output stage refills when empty or when its word leaves
  wire do_pop  = (cnt_r != {(AW+1){1'b0}}) && (!ov_r || out_ready);

  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = ov_r;
  assign out_data  = od_r;

  // storage write, no reset needed on data
  always @(posedge clk_sys) begin
    if (do_push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // indices, count and output stage
  always @(posedge clk_sys) begin
    if (!rstn) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      ov_r  <= 1'b0;
      od_r  <= {WIDTH{1'b0}};
    end else begin
      if (do_push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_pop) begin
        rp_r <= rp_r + 1'b1;
        od_r <= mem_r[rp_r];
        ov_r <= 1'b1;
      end else if (out_ready) begin
        ov_r <= 1'b0;
      end
      if (do_push && !do_pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule // rip_fifo

//--- rip_port.v
`timescale 1ns/10ps
`include "rip_regs.vh"
// ----------------------------------------------------------------------------
// serial slave port of the clock device
// ----------------------------------------------------------------------------
// scl and sda are sampled by clk_sys; the bus clock must stay well below the
// system clock (scl low for at least four system cycles). written bytes leave
// through a fifo; read data is fetched from rd_data, which must follow
// rd_target/rd_addr within one system cycle.
module rip_port #(
  parameter FIFO_DEPTH = 8,             // write fifo depth
  parameter FIFO_AW    = 3              // log2 of fifo depth
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // serial bus pins
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe,
  // power state levels
  input  wire        pwr_busy,
  input  wire        on_battery,
  // write stream towards the storage
  output wire        wr_valid,
  input  wire        wr_ready,
  output wire        wr_target,
  output wire [7:0]  wr_addr,
  output wire [7:0]  wr_data,
  // read port towards the storage
  output wire        rd_target,
  output wire [7:0]  rd_addr,
  input  wire [7:0]  rd_data,
  // status
  output wire        bus_active
);

  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam [3:0] ST_IDLE  = 4'h0;     // standby, waiting for start
  localparam [3:0] ST_ID    = 4'h1;     // receiving identifier byte
  localparam [3:0] ST_WADR  = 4'h2;     // receiving word address
  localparam [3:0] ST_WDAT  = 4'h3;     // receiving data byte
  localparam [3:0] ST_ACK   = 4'h4;     // driving acknowledge
  localparam [3:0] ST_TX    = 4'h5;     // sending a data byte
  localparam [3:0] ST_TXACK = 4'h6;     // reading master acknowledge
  localparam [3:0] ST_IGN   = 4'h7;     // ignoring until next start

  // --------------------------------------------------------------------------
  // pointer advance with wrap per target
  // --------------------------------------------------------------------------
  function [7:0] rip_next_ptr;
    input [7:0] ptr;
    input       tgt;
    begin
      if (tgt == `RIP_TGT_CSR && ptr >= `RIP_CSR_LAST) begin
        rip_next_ptr = `RIP_PTR_RST;
      end else if (tgt == `RIP_TGT_MEM && ptr >= `RIP_MEM_LAST) begin
        rip_next_ptr = `RIP_PTR_RST;
      end else begin
        rip_next_ptr = ptr + 8'h01;
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  wire [3:0] sync_w;                    // {on_battery, pwr_busy, sda, scl}
  wire       scl_s = sync_w[0];         // synchronised scl
  wire       sda_s = sync_w[1];         // synchronised sda
  wire       busy_s = sync_w[2];        // power-up sequence running
  wire       batt_s = sync_w[3];        // running from backup power

  // idle bus reads high, power levels reset to the safe side
  rip_sync #(
    .WIDTH   (4),
    .RST_VAL (4'b1111)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in ({on_battery, pwr_busy, sda_i, scl_i}),
    .sync_out (sync_w)
  );

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg       scl_d_r;                    // scl one cycle back
  reg       sda_d_r;                    // sda one cycle back
  reg [3:0] state_r;                    // main state
  reg [3:0] after_r;                    // state that follows acknowledge
  reg [2:0] bit_r;                      // bit index within a byte
  reg       full_r;                     // eight bits received
  reg [7:0] rx_r;                       // receive shift register
  reg [7:0] tx_r;                       // transmit shift register
  reg       oe_r;                       // sda pulled low
  reg       sda_o_r;                    // value on the open-drain pin
  reg       tgt_r;                      // selected target
  reg [7:0] ptr_r;                      // internal address pointer
  reg       mack_r;                     // master acknowledged
  reg       push_r;                     // fifo push strobe
  reg [16:0] push_d_r;                  // fifo push word
  reg       act_r;                      // transfer in progress

  // --------------------------------------------------------------------------
  // bus conditions seen on the synchronised lines
  // --------------------------------------------------------------------------
  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  // sda falling with scl high marks a start
  wire start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
  // sda rising with scl high marks a stop
  wire stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;
  wire fifo_ready;                      // room for one more written byte

  // identifier match on the complete byte
  wire id_csr = (rx_r[7:1] == `RIP_ID_CSR);
  wire id_mem = (rx_r[7:1] == `RIP_ID_MEM);

  // --------------------------------------------------------------------------
  // edge history
  // --------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // --------------------------------------------------------------------------
  // protocol engine
  // --------------------------------------------------------------------------
  // the bus conditions take priority over bit handling; a start is honoured
  // in any state unless power-up is running or on backup power, so a repeated start needs no stop before it
  always @(posedge clk_sys) begin
    if (!rstn) begin
      state_r  <= ST_IDLE;
      after_r  <= ST_IDLE;
      bit_r    <= 3'h0;
      full_r   <= 1'b0;
      rx_r     <= 8'h00;
      tx_r     <= 8'h00;
      oe_r     <= 1'b0;
      sda_o_r  <= 1'b0;
      tgt_r    <= `RIP_TGT_CSR;
      ptr_r    <= `RIP_PTR_RST;
      mack_r   <= 1'b0;
      push_r   <= 1'b0;
      push_d_r <= 17'h0_0000;
      act_r    <= 1'b0;
    end else begin
      push_r <= 1'b0;
      if (batt_s) begin
        // backup power: port off, pointer kept
        state_r <= ST_IDLE;
        oe_r    <= 1'b0;
        act_r   <= 1'b0;
      end else if (start_det && !busy_s) begin
        // start or repeated start, pointer kept for the read
        state_r <= ST_ID;
        bit_r   <= 3'h0;
        full_r  <= 1'b0;
        oe_r    <= 1'b0;
        act_r   <= 1'b1;
      end else if (stop_det) begin
        // back to standby
        state_r <= ST_IDLE;
        oe_r    <= 1'b0;
        act_r   <= 1'b0;
      end else begin
        case (state_r)
          // ------------------------------------------------------------------
          // receiving states share the shifter
          // ------------------------------------------------------------------
          ST_ID, ST_WADR, ST_WDAT: begin
            if (scl_rise) begin
              rx_r   <= {rx_r[6:0], sda_s};
              bit_r  <= bit_r + 3'h1;
              full_r <= (bit_r == `RIP_BIT_LAST);
            end else if (scl_fall && full_r) begin
              full_r <= 1'b0;
              bit_r  <= 3'h0;
              if (state_r == ST_ID) begin
                if (id_csr || id_mem) begin
                  // ack only after the whole byte matched
                  oe_r  <= 1'b1;
                  tgt_r <= id_mem ? `RIP_TGT_MEM : `RIP_TGT_CSR;
                  state_r <= ST_ACK;
                  // read goes straight out from the pointer
                  after_r <= (rx_r[0] == `RIP_DIR_READ) ? ST_TX : ST_WADR;
                end else begin
                  // not ours: stay off the bus until a start
                  state_r <= ST_IGN;
                end
              end else if (state_r == ST_WADR) begin
                // word address loads the pointer
                ptr_r   <= (tgt_r == `RIP_TGT_MEM) ? (rx_r & `RIP_MEM_MASK) : rx_r;
                oe_r    <= 1'b1;
                state_r <= ST_ACK;
                after_r <= ST_WDAT;
              end else if (fifo_ready) begin
                // single data byte goes to storage
                push_r   <= 1'b1;
                push_d_r <= {tgt_r, ptr_r, rx_r};
                ptr_r    <= rip_next_ptr(ptr_r, tgt_r);
                oe_r     <= 1'b1;
                state_r  <= ST_ACK;
                after_r  <= ST_IGN;
              end else begin
                // storage stalled: refuse the byte, no ack
                state_r <= ST_IGN;
              end
            end
          end
          // ------------------------------------------------------------------
          // acknowledge held for one scl period
          // ------------------------------------------------------------------
          ST_ACK: begin
            if (scl_fall) begin
              bit_r   <= 3'h0;
              state_r <= after_r;
              if (after_r == ST_TX) begin
                // first bit of the read byte goes out now
                tx_r <= rd_data;
                oe_r <= ~rd_data[7];
              end else begin
                oe_r <= 1'b0;
              end
            end
          end
          // ------------------------------------------------------------------
          // sending a byte, bit changes on scl falling edges
          // ------------------------------------------------------------------
          ST_TX: begin
            if (scl_fall) begin
              if (bit_r == `RIP_BIT_LAST) begin
                // release for the master acknowledge
                oe_r    <= 1'b0;
                ptr_r   <= rip_next_ptr(ptr_r, tgt_r);
                mack_r  <= 1'b0;
                state_r <= ST_TXACK;
              end else begin
                tx_r  <= {tx_r[6:0], 1'b0};
                oe_r  <= ~tx_r[6];
                bit_r <= bit_r + 3'h1;
              end
            end
          end
          // ------------------------------------------------------------------
          // master acknowledge decides on another byte
          // ------------------------------------------------------------------
          ST_TXACK: begin
            if (scl_rise) begin
              mack_r <= ~sda_s;
            end else if (scl_fall) begin
              bit_r <= 3'h0;
              if (mack_r) begin
                // another byte from the advanced pointer
                tx_r    <= rd_data;
                oe_r    <= ~rd_data[7];
                state_r <= ST_TX;
              end else begin
                // no ack: wait for the stop
                oe_r    <= 1'b0;
                state_r <= ST_IGN;
              end
            end
          end
          // ------------------------------------------------------------------
          // standby and ignore both keep sda released
          // ------------------------------------------------------------------
          ST_IDLE, ST_IGN: begin
            oe_r <= 1'b0;
          end
          default: begin
            state_r <= ST_IDLE;
            oe_r    <= 1'b0;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // write fifo
  // --------------------------------------------------------------------------
  // the fifo decouples the slow storage from the bus; when it is full the
  // data byte is refused rather than stretching scl
  wire [16:0] fifo_out;

  rip_fifo #(
    .WIDTH (17),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_valid  (push_r),
    .in_ready  (fifo_ready),
    .in_data   (push_d_r),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (fifo_out)
  );

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign wr_target  = fifo_out[16];
  assign wr_addr    = fifo_out[15:8];
  assign wr_data    = fifo_out[7:0];
  assign sda_o      = sda_o_r;
  assign sda_oe     = oe_r;
  assign rd_target  = tgt_r;
  assign rd_addr    = ptr_r;
  assign bus_active = act_r;

endmodule // rip_port

//--- rip_port_assertions.sv
`timescale 1ns/10ps
`include "rip_regs.vh"
// ----------------------------------------------------------------------
// pin level checker of the slave port
// ----------------------------------------------------------------------
module rip_port_chk (
  // clock and reset
  input wire       clk_sys,
  input wire       rstn,
  // bus and power levels
  input wire       scl_i,
  input wire       sda_i,
  input wire       sda_o,
  input wire       sda_oe,
  input wire       pwr_busy,
  input wire       on_battery,
  // storage side
  input wire       wr_valid,
  input wire       wr_ready,
  input wire       wr_target,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire       rd_target,
  input wire [7:0] rd_addr,
  input wire       bus_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // stop: data rises under a high clock, then stays high long enough to pass the synchroniser
  sequence stop_seen;
    (scl_i && $rose(sda_i)) ##1 (scl_i && sda_i) [*4];
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !sda_oe && !bus_active && !wr_valid && !rd_addr)
    else $error("outputs not cleared by reset");
  a_open_drain: assert property (sda_oe |-> !sda_o)
    else $error("pin driven high");
  a_battery_off: assert property (on_battery [*5] |-> !sda_oe && !bus_active)
    else $error("sda held on backup power");
  a_busy_nostart: assert property ((!bus_active && pwr_busy) [*5] |=> !bus_active)
    else $error("start taken during power-up");
  a_oe_scl_low: assert property ($changed(sda_oe) && !on_battery |-> !scl_i)
    else $error("sda changed while scl high");
  a_idle_quiet: assert property (!bus_active |-> !sda_oe)
    else $error("sda driven while idle");
  a_write_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_target, wr_addr, wr_data}))
    else $error("write word changed before taken");
  a_mem_range: assert property (rd_target == `RIP_TGT_MEM |-> rd_addr <= `RIP_MEM_LAST)
    else $error("memory pointer beyond last byte");
  a_stop_idle: assert property (stop_seen |=> !bus_active && !sda_oe)
    else $error("stop did not end transfer");
endmodule // rip_port_chk

bind rip_port rip_port_chk rip_port_chk_i (.clk_sys(clk_sys), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .pwr_busy(pwr_busy), .on_battery(on_battery), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_target(wr_target), .wr_addr(wr_addr), .wr_data(wr_data), .rd_target(rd_target),
  .rd_addr(rd_addr), .bus_active(bus_active));

//--- rip_master.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// bus master model: bit time 160 ns, low 100 ns, high 60 ns
// ----------------------------------------------------------------------
module rip_master (
  // bus lines
  output reg  scl,
  output reg  sda_dn,
  input  wire sda
);
  initial begin
    scl = 1'b1;
    sda_dn = 1'b0;
  end
  // pin moves land on clock edges; non-blocking updates make the port see them one cycle late, never racing
  // one pulse; data set early in low phase, sampled late in high phase
  task bit_x(input b, output s);
    begin
      #20 sda_dn <= ~b;
      #80 scl <= 1'b1;
      #58 s = sda;
      #2 scl <= 1'b0;
    end
  endtask
  // start or repeated start, clock left low
  task start;
    begin
      #20 sda_dn <= 1'b0;
      #80 scl <= 1'b1;
      #60 sda_dn <= 1'b1;
      #60 scl <= 1'b0;
    end
  endtask
  // stop, then bus idle
  task stop;
    begin
      #20 sda_dn <= 1'b1;
      #80 scl <= 1'b1;
      #60 sda_dn <= 1'b0;
      #200;
    end
  endtask
  // send a byte, return the device acknowledge
  task wbyte(input [7:0] b, output ack);
    integer i;
    reg     s;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_x(b[i], s);
      bit_x(1'b1, s);
      ack = ~s;
    end
  endtask
  // receive a byte, acknowledge only if more wanted
  task rbyte(input more, output [7:0] d);
    integer i;
    reg     s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_x(1'b1, s);
        d = {d[6:0], s};
      end
      bit_x(~more, s);
    end
  endtask
endmodule // rip_master

//--- rip_port_bench.sv
`timescale 1ns/10ps
`include "rip_regs.vh"
module rip_port_bench;
  // ----------------------------------------------------------------------
  // clock, wires and storage model
  // ----------------------------------------------------------------------
  reg          clk_sys = 1'b0;
  reg          rstn = 1'b0;
  reg          pwr_busy = 1'b0;
  reg          on_battery = 1'b0;
  reg          wr_ready = 1'b1;
  wire         scl, m_dn, sda_o, sda_oe, wr_valid, wr_target, rd_target, bus_active;
  wire [7:0]   wr_addr, wr_data, rd_addr, rd_data;
  wire         sda = !sda_oe && !m_dn;   // pulled up unless a party pulls low
  integer      err_count = 0;
  integer      total_checks = 0;
  integer      i, k;
  logic [16:0] pops [$];                 // words taken from the write stream
  logic [23:0] rows [4];                 // id, ack expected, address, data
  logic [7:0]  d;
  logic        a;
  always #10 clk_sys = ~clk_sys;
  // storage byte, distinct per target and place
  function automatic [7:0] mem_byte(input t, input [7:0] p);
    mem_byte = {p[6:0], t} ^ 8'h5a;
  endfunction
  assign rd_data = mem_byte(rd_target, rd_addr);
  rip_master rip_master_i (.scl(scl), .sda_dn(m_dn), .sda(sda));
  rip_port rip_port_i (.clk_sys(clk_sys), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .pwr_busy(pwr_busy), .on_battery(on_battery), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_target(wr_target), .wr_addr(wr_addr), .wr_data(wr_data), .rd_target(rd_target), .rd_addr(rd_addr),
    .rd_data(rd_data), .bus_active(bus_active));
  // words handed over, seen as the port sees them
  always @(posedge clk_sys) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) pops.push_back({wr_target, wr_addr, wr_data});
  end
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait for words on the write stream
  task wait_pops(input integer n);
    for (k = 0; k < 3000 && pops.size() < n; k = k + 1) @(posedge clk_sys);
    if (pops.size() < n) begin
      chk("write stream wait", 17'(n), 17'(pops.size()));
      tally_and_finish;
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rows = '{{7'h6f, 1'b1, 8'h05, 8'ha5}, {7'h57, 1'b1, 8'h7f, 8'h3c},
             {7'h55, 1'b0, 8'h11, 8'h22}, {7'h6e, 1'b0, 8'h05, 8'h00}};
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("reset outputs", 17'h0_0000, {sda_oe, bus_active, wr_valid, rd_target, rd_addr});
    // first read with no word address starts at zero
    rip_master_i.start;
    rip_master_i.wbyte({`RIP_ID_MEM, `RIP_DIR_READ}, a);
    rip_master_i.rbyte(1'b0, d);
    rip_master_i.stop;
    chk("current read", 17'(mem_byte(1'b1, 8'h00)), 17'(d));
    $display("test current read done");
    // ordinary writes and foreign identifiers
    for (i = 0; i < 4; i = i + 1) begin
      rip_master_i.start;
      rip_master_i.wbyte({rows[i][23:17], 1'b0}, a);
      chk("id ack", 17'(rows[i][16]), 17'(a));
      if (rows[i][16]) begin
        rip_master_i.wbyte(rows[i][15:8], a);
        chk("addr ack", 17'h0_0001, 17'(a));
        rip_master_i.wbyte(rows[i][7:0], a);
        chk("data ack", 17'h0_0001, 17'(a));
      end
      rip_master_i.stop;
      if (rows[i][16]) begin
        wait_pops(1);
        chk("write word", {rows[i][23:17] == `RIP_ID_MEM, rows[i][15:0]}, pops.pop_front());
      end
      repeat (20) @(posedge clk_sys);
      chk("no stray word", 17'h0_0000, 17'(pops.size()));
    end
    $display("test write rows done");
    // random read over the wrap of the clock space
    rip_master_i.start;
    rip_master_i.wbyte({`RIP_ID_CSR, 1'b0}, a);
    rip_master_i.wbyte(8'h2e, a);
    rip_master_i.start;
    rip_master_i.wbyte({`RIP_ID_CSR, `RIP_DIR_READ}, a);
    chk("read id ack", 17'h0_0001, 17'(a));
    for (i = 0; i < 3; i = i + 1) begin
      rip_master_i.rbyte(i < 2, d);
      chk("read byte", 17'(mem_byte(1'b0, (8'h2e + i) % 8'h30)), 17'(d));
    end
    rip_master_i.stop;
    $display("test random read done");
    // power-up sequence, then backup power
    for (i = 0; i < 2; i = i + 1) begin
      {on_battery, pwr_busy} <= 2'b01 << i;
      repeat (6) @(posedge clk_sys);
      rip_master_i.start;
      rip_master_i.wbyte({`RIP_ID_CSR, 1'b0}, a);
      rip_master_i.stop;
      chk("power state ack", 17'h0_0000, 17'(a));
      {on_battery, pwr_busy} <= 2'b00;
      repeat (6) @(posedge clk_sys);
    end
    $display("test power states done");
    // fill the write path while storage stalls, then drain
    wr_ready <= 1'b0;
    for (i = 0; i < 10; i = i + 1) begin
      rip_master_i.start;
      rip_master_i.wbyte({`RIP_ID_CSR, 1'b0}, a);
      rip_master_i.wbyte(8'(i), a);
      rip_master_i.wbyte(8'(i), a);
      rip_master_i.stop;
      chk("fill ack", 17'(i < 9), 17'(a));
    end
    wr_ready <= 1'b1;
    wait_pops(9);
    repeat (20) @(posedge clk_sys);
    chk("drained count", 17'h0_0009, 17'(pops.size()));
    chk("last word", 17'h0_0808, pops[8]);
    $display("test fifo done");
    // reset in mid-run: pointer left at 09h must return to zero
    rstn <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("mid reset outputs", 17'h0_0000, {sda_oe, bus_active, wr_valid, rd_target, rd_addr});
    rip_master_i.start;
    rip_master_i.wbyte({`RIP_ID_CSR, `RIP_DIR_READ}, a);
    chk("mid reset id ack", 17'h0_0001, 17'(a));
    rip_master_i.rbyte(1'b0, d);
    rip_master_i.stop;
    chk("mid reset read", 17'(mem_byte(1'b0, 8'h00)), 17'(d));
    $display("test mid reset done");
    tally_and_finish;
  end
endmodule // rip_port_bench
